// file: verilog/tw_pkg.sv
// tw_pkg: register map, field positions, reset values and timing constants
// assumes a 32-bit AXI4-Lite slave decoding the low address byte only
package tw_pkg;
    // register byte addresses
    localparam logic [7:0] TW_ADDR_PRESCALER = 8'h00;
    localparam logic [7:0] TW_ADDR_PRESET = 8'h04;
    localparam logic [7:0] TW_ADDR_CTRL_STATUS = 8'h08;
    localparam logic [7:0] TW_ADDR_WD_RELOAD = 8'h0C;
    localparam logic [7:0] TW_ADDR_WD_SERVICE = 8'h10;
    localparam logic [7:0] TW_ADDR_WD_CONFIG = 8'h14;
    // control/status fields
    localparam int TW_CS_RESTART = 0;
    localparam int TW_CS_TERMINAL = 1;
    localparam int TW_CS_IRQ_EN = 2;
    localparam int TW_CS_PENDING = 3;
    localparam int TW_CS_FREEZE_EN = 4;
    // watchdog config fields
    localparam int TW_CFG_KEY_EN = 0;
    localparam int TW_CFG_CLK_TICK = 1;
    // prescaler field
    localparam int TW_DIV_MSB = 2;
    localparam logic [2:0] TW_DIV_CODE_MAX = 3'h5;
    // reset values and service key
    localparam logic [2:0] TW_DIV_RST = 3'h0;
    localparam logic [15:0] TW_PRESET_RST = 16'hFFFF;
    localparam logic [7:0] TW_RELOAD_RST = 8'h0F;
    localparam logic [7:0] TW_SERVICE_KEY = 8'h5C;
    // axi responses
    localparam logic [1:0] TW_RESP_OKAY = 2'h0;
    localparam logic [1:0] TW_RESP_SLVERR = 2'h2;

    // last divider count for a divide code; reserved codes divide by 32
    function automatic logic [4:0] tw_div_last(input logic [2:0] code);
        logic [2:0] c;
        c = (code > TW_DIV_CODE_MAX) ? TW_DIV_CODE_MAX : code;
        tw_div_last = 5'((6'h01 << c) - 6'h01);
    endfunction : tw_div_last
endpackage : tw_pkg

// file: verilog/tw_tick_timer.sv
// tw_tick_timer: slow-clock prescaler and 16-bit reloading periodic timer
// assumes slow_edge is a one-cycle pulse per synchronised slow clock edge
`timescale 1ns/100ps
module tw_tick_timer
    import tw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow_edge,
    input wire logic [2:0] divide_code,
    input wire logic [15:0] preset,
    input wire logic freeze,
    input wire logic freeze_enable,
    input wire logic restart_req,
    output logic tick,
    output logic terminal,
    output logic restart_done,
    output logic pulse_level
);
    logic [4:0] div_r, div_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;
    logic term_r, term_nxt;
    logic done_r, done_nxt;
    logic lvl_r, lvl_nxt;

    always_comb begin
        div_nxt = div_r;
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r;
        term_nxt = 1'b0;
        done_nxt = 1'b0;
        lvl_nxt = lvl_r;
        if (slow_edge) begin
            if (div_r >= tw_div_last(divide_code)) begin
                div_nxt = 5'h00;
                tick_nxt = 1'b1;
            end else begin
                div_nxt = div_r + 5'h01;
            end
        end
        if (tick_r) begin
            lvl_nxt = 1'b0;
            if (restart_req) begin
                cnt_nxt = preset;
                done_nxt = 1'b1;
            end else if (!(freeze_enable && freeze)) begin
                if (cnt_r == 16'h0000) begin
                    cnt_nxt = preset;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                    if (cnt_r == 16'h0001) begin
                        term_nxt = 1'b1;
                        lvl_nxt = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 5'h00;
            tick_r <= 1'b0;
            cnt_r <= TW_PRESET_RST;
            term_r <= 1'b0;
            done_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            cnt_r <= cnt_nxt;
            term_r <= term_nxt;
            done_r <= done_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign tick = tick_r;
    assign terminal = term_r;
    assign restart_done = done_r;
    assign pulse_level = lvl_r;
endmodule : tw_tick_timer

// file: verilog/tw_watchdog.sv
// tw_watchdog: 8-bit watchdog counter with reload and key-match servicing
// assumes wd_edge and slow_edge are one-cycle pulses on clk
`timescale 1ns/100ps
module tw_watchdog
    import tw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wd_edge,
    input wire logic slow_edge,
    input wire logic reload_wr,
    input wire logic [7:0] reload_val,
    input wire logic key_wr,
    input wire logic [7:0] key_val,
    input wire logic key_enable,
    output logic pending,
    output logic error
);
    logic run_r, run_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic served_r, served_nxt;
    logic pend_r, pend_nxt;
    logic err_r, err_nxt;
    logic key_ok;

    assign key_ok = key_wr && key_enable && (key_val == TW_SERVICE_KEY);

    always_comb begin
        run_nxt = run_r;
        cnt_nxt = cnt_r;
        served_nxt = served_r;
        pend_nxt = pend_r;
        err_nxt = err_r;
        if (wd_edge && run_r) begin
            served_nxt = 1'b0;
            if (cnt_r == 8'h00) begin
                err_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
        end
        if (slow_edge) begin
            pend_nxt = 1'b0;
        end
        if (reload_wr) begin
            run_nxt = 1'b1;
            cnt_nxt = reload_val;
            pend_nxt = 1'b1;
        end else if (key_wr && key_enable) begin
            pend_nxt = 1'b1;
            if (!key_ok) begin
                err_nxt = 1'b1;
            end else if (served_r && !wd_edge) begin
                err_nxt = 1'b1;
            end else begin
                run_nxt = 1'b1;
                cnt_nxt = reload_val;
                served_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 1'b0;
            cnt_r <= TW_RELOAD_RST;
            served_r <= 1'b0;
            pend_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            cnt_r <= cnt_nxt;
            served_r <= served_nxt;
            pend_r <= pend_nxt;
            err_r <= err_nxt;
        end
    end

    assign pending = pend_r;
    assign error = err_r;
endmodule : tw_watchdog

// file: verilog/tw_top.sv
// tw_top: timing and watchdog unit with AXI4-Lite register access
// assumes SLOW_CLK and FREEZE are asynchronous pins, slow clock <= CLK/4
`timescale 1ns/100ps
module tw_top
    import tw_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SLOW_CLK,
    input wire logic FREEZE,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic TIMER_PULSE,
    output logic TIMER_IRQ,
    output logic WDOG_RESET_REQ
);
    // pin synchronisers
    logic [1:0] slow_sync_r;
    logic [1:0] frz_sync_r;
    logic slow_prev_r;
    logic slow_edge;

    // axi write path
    logic aw_full_r, aw_full_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic w_full_r, w_full_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic wr_go;

    // axi read path
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic rd_go;

    // registers
    logic [2:0] div_code_r, div_code_nxt;
    logic [15:0] preset_r, preset_nxt;
    logic restart_r, restart_nxt;
    logic flag_r, flag_nxt;
    logic irq_en_r, irq_en_nxt;
    logic frz_en_r, frz_en_nxt;
    logic [7:0] reload_r, reload_nxt;
    logic key_en_r, key_en_nxt;
    logic clk_tick_r, clk_tick_nxt;
    logic irq_r, irq_nxt;
    logic pulse_r, pulse_nxt;
    logic wdrst_r, wdrst_nxt;

    // internal events
    logic tick, terminal, restart_done, pulse_level;
    logic wd_pending, wd_error;
    logic reload_wr, key_wr;

    // address decode used by both paths
    function automatic logic tw_mapped(input logic [7:0] a);
        tw_mapped = (a == TW_ADDR_PRESCALER) || (a == TW_ADDR_PRESET) ||
            (a == TW_ADDR_CTRL_STATUS) || (a == TW_ADDR_WD_RELOAD) ||
            (a == TW_ADDR_WD_SERVICE) || (a == TW_ADDR_WD_CONFIG);
    endfunction : tw_mapped

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            slow_sync_r <= 2'h0;
            frz_sync_r <= 2'h0;
            slow_prev_r <= 1'b0;
        end else begin
            slow_sync_r <= {slow_sync_r[0], SLOW_CLK};
            frz_sync_r <= {frz_sync_r[0], FREEZE};
            slow_prev_r <= slow_sync_r[1];
        end
    end
    assign slow_edge = slow_sync_r[1] && !slow_prev_r;

    assign wr_go = aw_full_r && w_full_r && !bvalid_r;
    assign rd_go = S_AXI_ARVALID && arready_r;
    assign reload_wr = wr_go && (aw_addr_r == TW_ADDR_WD_RELOAD) &&
        w_strb_r[0];
    assign key_wr = wr_go && (aw_addr_r == TW_ADDR_WD_SERVICE) &&
        w_strb_r[0];

    // axi handshakes
    always_comb begin
        aw_full_nxt = aw_full_r;
        aw_addr_nxt = aw_addr_r;
        w_full_nxt = w_full_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        if (S_AXI_AWVALID && awready_r) begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_r) begin
            w_full_nxt = 1'b1;
            w_data_nxt = S_AXI_WDATA;
            w_strb_nxt = S_AXI_WSTRB;
        end
        if (wr_go) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = tw_mapped(aw_addr_r) ? TW_RESP_OKAY : TW_RESP_SLVERR;
        end else if (bvalid_r && S_AXI_BREADY) begin
            bvalid_nxt = 1'b0;
        end
        awready_nxt = !aw_full_nxt;
        wready_nxt = !w_full_nxt;
        if (rd_go) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = tw_mapped(S_AXI_ARADDR) ? TW_RESP_OKAY
                : TW_RESP_SLVERR;
        end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    // register file and read data
    always_comb begin
        div_code_nxt = div_code_r;
        preset_nxt = preset_r;
        restart_nxt = restart_r;
        flag_nxt = flag_r;
        irq_en_nxt = irq_en_r;
        frz_en_nxt = frz_en_r;
        reload_nxt = reload_r;
        key_en_nxt = key_en_r;
        clk_tick_nxt = clk_tick_r;
        rdata_nxt = rdata_r;
        if (restart_done) begin
            restart_nxt = 1'b0;
        end
        if (wr_go && w_strb_r[0]) begin
            unique case (aw_addr_r)
                TW_ADDR_PRESCALER: div_code_nxt = w_data_r[TW_DIV_MSB:0];
                TW_ADDR_PRESET: preset_nxt[7:0] = w_data_r[7:0];
                TW_ADDR_CTRL_STATUS: begin
                    if (w_data_r[TW_CS_RESTART]) begin
                        restart_nxt = 1'b1;
                    end
                    irq_en_nxt = w_data_r[TW_CS_IRQ_EN];
                    frz_en_nxt = w_data_r[TW_CS_FREEZE_EN];
                end
                TW_ADDR_WD_RELOAD: reload_nxt = w_data_r[7:0];
                TW_ADDR_WD_CONFIG: begin
                    key_en_nxt = w_data_r[TW_CFG_KEY_EN];
                    clk_tick_nxt = w_data_r[TW_CFG_CLK_TICK];
                end
                default: ;
            endcase
        end
        if (wr_go && w_strb_r[1] && (aw_addr_r == TW_ADDR_PRESET)) begin
            preset_nxt[15:8] = w_data_r[15:8];
        end
        if (rd_go) begin
            rdata_nxt = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                TW_ADDR_PRESCALER: rdata_nxt[TW_DIV_MSB:0] = div_code_r;
                TW_ADDR_PRESET: rdata_nxt[15:0] = preset_r;
                TW_ADDR_CTRL_STATUS: begin
                    rdata_nxt[TW_CS_RESTART] = restart_r;
                    rdata_nxt[TW_CS_TERMINAL] = flag_r;
                    rdata_nxt[TW_CS_IRQ_EN] = irq_en_r;
                    rdata_nxt[TW_CS_PENDING] = wd_pending;
                    rdata_nxt[TW_CS_FREEZE_EN] = frz_en_r;
                    flag_nxt = 1'b0;
                end
                TW_ADDR_WD_CONFIG: begin
                    rdata_nxt[TW_CFG_KEY_EN] = key_en_r;
                    rdata_nxt[TW_CFG_CLK_TICK] = clk_tick_r;
                end
                default: ;
            endcase
        end
        // terminal sets flag, wins over clear
        if (terminal) begin
            flag_nxt = 1'b1;
        end
        irq_nxt = terminal && irq_en_r;
        pulse_nxt = pulse_level;
        wdrst_nxt = wdrst_r || wd_error;
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_full_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= TW_RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= TW_RESP_OKAY;
            div_code_r <= TW_DIV_RST;
            restart_r <= 1'b0;
            flag_r <= 1'b0;
            irq_en_r <= 1'b0;
            frz_en_r <= 1'b0;
            preset_r <= TW_PRESET_RST;
            reload_r <= TW_RELOAD_RST;
            key_en_r <= 1'b0;
            clk_tick_r <= 1'b0;
            irq_r <= 1'b0;
            pulse_r <= 1'b0;
            wdrst_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_full_r <= w_full_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            div_code_r <= div_code_nxt;
            restart_r <= restart_nxt;
            flag_r <= flag_nxt;
            irq_en_r <= irq_en_nxt;
            frz_en_r <= frz_en_nxt;
            preset_r <= preset_nxt;
            reload_r <= reload_nxt;
            key_en_r <= key_en_nxt;
            clk_tick_r <= clk_tick_nxt;
            irq_r <= irq_nxt;
            pulse_r <= pulse_nxt;
            wdrst_r <= wdrst_nxt;
        end
    end

    tw_tick_timer u_timer (
        .clk(CLK),
        .rst_n(RSTN),
        .slow_edge(slow_edge),
        .divide_code(div_code_r),
        .preset(preset_r),
        .freeze(frz_sync_r[1]),
        .freeze_enable(frz_en_r),
        .restart_req(restart_r),
        .tick(tick),
        .terminal(terminal),
        .restart_done(restart_done),
        .pulse_level(pulse_level)
    );

    // watchdog clocked by tick or by terminal pulse
    tw_watchdog u_wdog (
        .clk(CLK),
        .rst_n(RSTN),
        .wd_edge(clk_tick_r ? tick : terminal),
        .slow_edge(slow_edge),
        .reload_wr(reload_wr),
        .reload_val(reload_wr ? w_data_r[7:0] : reload_r),
        .key_wr(key_wr),
        .key_val(w_data_r[7:0]),
        .key_enable(key_en_r),
        .pending(wd_pending),
        .error(wd_error)
    );

    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign TIMER_PULSE = pulse_r;
    assign TIMER_IRQ = irq_r;
    assign WDOG_RESET_REQ = wdrst_r;
endmodule : tw_top

// file: sim/tw_top_properties.sv
// tw_top_properties: port-level checks of the timer and watchdog unit
// assumes binding onto tw_top, slow clock at most a quarter of CLK
`timescale 1ns/100ps
module tw_top_properties
    import tw_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic TIMER_PULSE,
    input wire logic TIMER_IRQ,
    input wire logic WDOG_RESET_REQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
    bad_read_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        && S_AXI_ARADDR > TW_ADDR_WD_CONFIG |-> ##[1:2] S_AXI_RVALID
        && S_AXI_RRESP == TW_RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
        else $error("unmapped read not refused");
    bad_write_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY && S_AXI_AWADDR > TW_ADDR_WD_CONFIG
        |-> ##[1:3] S_AXI_BVALID && S_AXI_BRESP == TW_RESP_SLVERR)
        else $error("unmapped write not refused");
    irq_single_a: assert property (TIMER_IRQ |=> !TIMER_IRQ)
        else $error("timer interrupt longer than one cycle");
    pulse_width_a: assert property ($rose(TIMER_PULSE) |-> TIMER_PULSE[*4])
        else $error("terminal pulse shorter than a tick");
    wdog_sticky_a: assert property (WDOG_RESET_REQ |=> WDOG_RESET_REQ)
        else $error("watchdog reset request withdrawn");
    reset_quiet_a: assert property ($rose(RSTN) |-> !WDOG_RESET_REQ
        && !TIMER_IRQ && !TIMER_PULSE && !S_AXI_BVALID && !S_AXI_RVALID)
        else $error("outputs active after reset");

    cover property (TIMER_IRQ);
    cover property ($rose(WDOG_RESET_REQ));
    cover property (S_AXI_RVALID && S_AXI_RRESP == TW_RESP_SLVERR);
endmodule : tw_top_properties

// file: sim/tw_top_tb_top.sv
// tw_top_tb_top: self-checking bench for the timer and watchdog unit
// assumes tw_pkg compiled first; slow clock made here at CLK/4
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module tw_top_tb_top
    import tw_pkg::*;
;
    logic CLK = 1'b0, RSTN = 1'b0, SLOW_CLK = 1'b0, FREEZE = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, TIMER_PULSE, TIMER_IRQ, WDOG_RESET_REQ;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs, sdiv = 2'h0;
    logic [31:0] S_AXI_RDATA, rd;
    logic slow_run = 1'b1, pp = 1'b0;
    int error_cnt = 0, checks = 0, irq_cnt = 0, rise_cnt = 0;
    int mdl[6];
    int hi, per, p, t0;

    tw_top tw_top_inst (.*);

    always #50 CLK = ~CLK;
    // slow clock and event counters
    always @(posedge CLK) begin
        if (slow_run) begin
            sdiv <= sdiv + 2'h1;
            SLOW_CLK <= sdiv[1];
        end
        pp <= TIMER_PULSE;
        irq_cnt <= irq_cnt + int'(TIMER_IRQ === 1'b1);
        rise_cnt <= rise_cnt + int'(TIMER_PULSE === 1'b1 && pp === 1'b0);
    end

    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic tmo(input bit bad);
        if (bad) begin
            error_cnt++;
            $display("unexpected at %0t: no answer", $time);
            end_sim();
        end
    endtask : tmo

    task automatic rst;
        RSTN <= 1'b0;
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        mdl = '{32'h0000_0000, 32'h0000_FFFF, 0, 0, 0, 0};
    endtask : rst

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1 && n < 50);
        rs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
        tmo(n >= 50);
        if (a < 8'h18) mdl[a[4:2]] = d;
    endtask : axw

    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1 && n < 50);
        rd = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        tmo(n >= 50);
    endtask : axr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        axr(a);
        `CHK(rs, TW_RESP_OKAY)
        `CHK(rd & m, e)
    endtask : rdchk

    // one terminal pulse period and its high time
    task automatic meas;
        hi = 0;
        per = 0;
        do begin
            @(posedge CLK);
            per++;
            if (TIMER_PULSE === 1'b1) hi++;
        end while (!(TIMER_PULSE === 1'b1 && pp === 1'b0) && per < 3000);
        tmo(per >= 3000);
    endtask : meas

    initial begin
        void'($urandom(79));
        rst();
        rdchk(TW_ADDR_PRESCALER, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk(TW_ADDR_PRESET, 32'hFFFF_FFFF, 32'h0000_FFFF);
        rdchk(TW_ADDR_CTRL_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk(TW_ADDR_WD_RELOAD, 32'hFFFF_FFFF, 32'h0000_0000);
        axr(8'h18);
        `CHK(rs, TW_RESP_SLVERR)
        axw(8'h18, 32'h0000_0001);
        `CHK(rs, TW_RESP_SLVERR)
        for (int c = 0; c < 6; c++) begin
            p = 1 + $urandom % 3;
            axw(TW_ADDR_PRESCALER, c);
            axw(TW_ADDR_PRESET, p);
            rdchk(TW_ADDR_PRESET, 32'hFFFF_FFFF, mdl[1]);
            axw(TW_ADDR_CTRL_STATUS, 32'h0000_0005);
            meas();
            meas();
            t0 = irq_cnt;
            meas();
            `CHK(per, (p + 1) * (4 << c))
            `CHK(hi, 4 << c)
            `CHK(irq_cnt - t0, 1)
        end
        repeat (10) @(posedge CLK);
        rdchk(TW_ADDR_CTRL_STATUS, 32'h0000_0002, 32'h0000_0002);
        rdchk(TW_ADDR_CTRL_STATUS, 32'h0000_0002, 32'h0000_0000);
        axw(TW_ADDR_CTRL_STATUS, 32'h0000_0006);
        rdchk(TW_ADDR_CTRL_STATUS, 32'h0000_0006, 32'h0000_0004);
        axw(TW_ADDR_CTRL_STATUS, 32'h0000_0000);
        t0 = irq_cnt;
        hi = rise_cnt;
        repeat (1200) @(posedge CLK);
        `CHK(irq_cnt - t0, 0)
        `CHK(rise_cnt > hi, 1'b1)
        axw(TW_ADDR_CTRL_STATUS, 32'h0000_0010);
        rdchk(TW_ADDR_CTRL_STATUS, 32'h0000_0010, 32'h0000_0010);
        FREEZE <= 1'b1;
        repeat (8) @(posedge CLK);
        hi = rise_cnt;
        repeat (1200) @(posedge CLK);
        `CHK(rise_cnt - hi, 0)
        axw(TW_ADDR_CTRL_STATUS, 32'h0000_0000);
        hi = rise_cnt;
        repeat (1200) @(posedge CLK);
        `CHK(rise_cnt > hi, 1'b1)
        FREEZE <= 1'b0;
        slow_run <= 1'b0;
        repeat (4) @(posedge CLK);
        axw(TW_ADDR_CTRL_STATUS, 32'h0000_0001);
        axw(TW_ADDR_WD_RELOAD, 32'h0000_0040);
        rdchk(TW_ADDR_CTRL_STATUS, 32'h0000_0009, 32'h0000_0009);
        slow_run <= 1'b1;
        repeat (300) @(posedge CLK);
        rdchk(TW_ADDR_CTRL_STATUS, 32'h0000_0009, 32'h0000_0000);
        rst();
        axw(TW_ADDR_WD_CONFIG, 32'h0000_0003);
        repeat (100) @(posedge CLK);
        `CHK(WDOG_RESET_REQ, 1'b0)
        axw(TW_ADDR_WD_SERVICE, {24'h00_0000, TW_SERVICE_KEY});
        repeat (48) @(posedge CLK);
        `CHK(WDOG_RESET_REQ, 1'b0)
        repeat (40) @(posedge CLK);
        `CHK(WDOG_RESET_REQ, 1'b1)
        rst();
        axw(TW_ADDR_WD_CONFIG, 32'h0000_0002);
        p = 4 + $urandom % 5;
        repeat (6) begin
            axw(TW_ADDR_WD_RELOAD, p);
            repeat (8) @(posedge CLK);
        end
        axw(TW_ADDR_WD_SERVICE, 32'h0000_0033);
        repeat (4 * p - 12) @(posedge CLK);
        `CHK(WDOG_RESET_REQ, 1'b0)
        repeat (24) @(posedge CLK);
        `CHK(WDOG_RESET_REQ, 1'b1)
        rst();
        axw(TW_ADDR_WD_CONFIG, 32'h0000_0003);
        axw(TW_ADDR_WD_SERVICE, 32'h0000_0033);
        repeat (10) @(posedge CLK);
        `CHK(WDOG_RESET_REQ, 1'b1)
        rst();
        axw(TW_ADDR_WD_CONFIG, 32'h0000_0003);
        slow_run <= 1'b0;
        repeat (4) @(posedge CLK);
        axw(TW_ADDR_WD_SERVICE, {24'h00_0000, TW_SERVICE_KEY});
        axw(TW_ADDR_WD_SERVICE, {24'h00_0000, TW_SERVICE_KEY});
        repeat (4) @(posedge CLK);
        `CHK(WDOG_RESET_REQ, 1'b1)
        end_sim();
    end
endmodule : tw_top_tb_top

bind tw_top tw_top_properties tw_top_properties_inst (.*);
